// ---- verilog/hwd_pkg.sv ----
// Constants and state types shared by the hardware watchdog files.
// How it works
// - After any reset the watchdog is off and does not count until the key sequence is done.
// - Writing 8'h1e then 8'he1 to the service key register at 8'ha6 starts the watchdog.
// - Once on, the count steps once per 2^sel machine cycles while the oscillator runs, else holds.
// - Once on, no software write turns it off; only hardware reset or its own overflow does.
// - The 14-bit counter overflows on reaching 14'h3fff, and that resets the whole device.
// - On overflow a high reset pulse of 96 peripheral clock periods is driven on the reset pin.
// - The service key register is write only; reads give no meaningful value.
// - The count itself can be neither read nor loaded through any register.
// - A 2^7 prescaler stage extends the time-out range by up to a factor of 128.
// - The time-out select register at 8'ha7 holds a three-bit select in its low bits.
// - The upper bits of the time-out select register are not stored and read as zero; software writes zeros.
// - At reset the three-bit time-out select clears to 3'b000.
// - After power-down is left by an external interrupt, counting waits until that input is high.
package hwd_pkg;

  localparam logic [7:0] HWD_ADDR_SERVICE_KEY = 8'ha6;
  localparam logic [7:0] HWD_ADDR_TIMEOUT_SEL = 8'ha7;
  localparam logic [7:0] HWD_KEY_FIRST = 8'h1e;
  localparam logic [7:0] HWD_KEY_SECOND = 8'he1;

  localparam int HWD_SEL_LSB = 0;
  localparam int HWD_SEL_MSB = 2;
  localparam logic [2:0] HWD_SEL_RESET = 3'h0;
  localparam logic [7:0] HWD_RDATA_RESET = 8'h00;

  localparam logic [13:0] HWD_CNT_RESET = 14'h0000;
  localparam logic [13:0] HWD_CNT_MAX = 14'h3fff;
  localparam logic [13:0] HWD_CNT_BEFORE_MAX = 14'h3ffe;
  localparam logic [6:0] HWD_PRE_RESET = 7'h00;
  localparam logic [6:0] HWD_PRE_ALL = 7'h7f;

  localparam logic [6:0] HWD_PULSE_PERIODS = 7'h60;
  localparam logic [6:0] HWD_PULSE_LAST = 7'h5f;
  localparam logic [6:0] HWD_PULSE_CNT_RESET = 7'h00;

  typedef struct packed {
    logic enabled;
    logic armed;
    logic hold;
    logic ovf;
    logic [2:0] sel;
    logic [13:0] cnt;
    logic [6:0] pre;
    logic [7:0] rdata;
  } hwd_state_t;

  typedef struct packed {
    logic active;
    logic [6:0] cnt;
  } hwd_pulse_t;

endpackage : hwd_pkg

// ---- verilog/hwd_reset_pulse.sv ----
// Reset pin pulse stretcher that counts peripheral clock periods.
`timescale 1ns/1ps
module hwd_reset_pulse
  import hwd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic periph_tick,
  output logic pulse
);

  hwd_pulse_t s_r;
  hwd_pulse_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (start && !s_r.active)
    begin
      s_nxt.active = 1'b1;
      s_nxt.cnt = HWD_PULSE_CNT_RESET;
    end
    else if (s_r.active && periph_tick)
    begin
      if (s_r.cnt == HWD_PULSE_LAST)
      begin
        s_nxt.active = 1'b0;
        s_nxt.cnt = HWD_PULSE_CNT_RESET;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign pulse = s_r.active;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  pulse_starts_a: assert property (start && !pulse |=> pulse)
    else $error("Reset pulse did not start after overflow.");
  pulse_ends_a: assert property (pulse && periph_tick && s_r.cnt == HWD_PULSE_LAST |=> !pulse)
    else $error("Reset pulse outlived its period count.");
  pulse_holds_a: assert property (pulse && !(periph_tick && s_r.cnt == HWD_PULSE_LAST) |=> pulse)
    else $error("Reset pulse ended early.");
  pulse_bound_a: assert property (s_r.cnt < HWD_PULSE_PERIODS)
    else $error("Reset pulse period count out of range.");

endmodule : hwd_reset_pulse

// ---- verilog/hwd_watchdog.sv ----
// Hardware watchdog with key-sequence service register and reset pin pulse.
`timescale 1ns/1ps
module hwd_watchdog
  import hwd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic mcycle_tick,
  input wire logic osc_running,
  input wire logic pd_int_wake,
  input wire logic ext_int_n,
  input wire logic periph_tick,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  output logic wdt_enabled
);

  hwd_state_t s_r;
  hwd_state_t s_nxt;
  logic pulse;
  logic wr_key;
  logic key_done;
  logic run;
  logic pre_full;
  logic [6:0] pre_mask;

  // Only the low select bits of the prescaler must be all ones for the counter to step.
  assign pre_mask = ~(HWD_PRE_ALL << s_r.sel);
  assign pre_full = (s_r.pre & pre_mask) == pre_mask;
  assign wr_key = sfr_wr && (sfr_addr == HWD_ADDR_SERVICE_KEY);
  assign key_done = wr_key && s_r.armed && (sfr_wdata == HWD_KEY_SECOND);
  // A held interrupt line after power-down wake keeps the count frozen.
  assign run = s_r.enabled && mcycle_tick && osc_running && !s_r.hold;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ovf = 1'b0;

    // Any write anywhere breaks a pending sequence unless it is the first key again.
    if (sfr_wr)
    begin
      s_nxt.armed = wr_key && (sfr_wdata == HWD_KEY_FIRST);
    end

    // Upper bits are not stored, so they read as zero whatever was written.
    if (sfr_wr && (sfr_addr == HWD_ADDR_TIMEOUT_SEL))
    begin
      s_nxt.sel = sfr_wdata[HWD_SEL_MSB:HWD_SEL_LSB];
    end

    if (pd_int_wake)
    begin
      s_nxt.hold = 1'b1;
    end
    else if (ext_int_n)
    begin
      s_nxt.hold = 1'b0;
    end

    if (run)
    begin
      s_nxt.pre = s_r.pre + 7'h01;
      if (pre_full)
      begin
        s_nxt.cnt = s_r.cnt + 14'h0001;
        if (s_r.cnt == HWD_CNT_BEFORE_MAX)
        begin
          s_nxt.ovf = 1'b1;
        end
      end
    end

    if (key_done)
    begin
      s_nxt.enabled = 1'b1;
      s_nxt.cnt = HWD_CNT_RESET;
      s_nxt.pre = HWD_PRE_RESET;
    end

    // Overflow and the pulse that follows act as a device reset, so they beat a key write.
    if (s_nxt.ovf || s_r.ovf || pulse)
    begin
      s_nxt.enabled = 1'b0;
      s_nxt.armed = 1'b0;
      s_nxt.cnt = HWD_CNT_RESET;
      s_nxt.pre = HWD_PRE_RESET;
      s_nxt.sel = HWD_SEL_RESET;
    end

    // The count has no read path; the key register reads as zero.
    if (sfr_rd)
    begin
      if (sfr_addr == HWD_ADDR_TIMEOUT_SEL)
      begin
        s_nxt.rdata = {5'h00, s_r.sel};
      end
      else
      begin
        s_nxt.rdata = HWD_RDATA_RESET;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  hwd_reset_pulse u_pulse (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(s_r.ovf),
    .periph_tick(periph_tick),
    .pulse(pulse)
  );

  // The pin is only driven during the pulse so an external reset can still pull it.
  assign rst_pin_o = pulse;
  assign rst_pin_oe = pulse;
  assign sfr_rdata = s_r.rdata;
  assign wdt_enabled = s_r.enabled;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  idle_until_key_a: assert property (!s_r.enabled && !key_done |=> !s_r.enabled)
    else $error("Watchdog enabled without the key sequence.");

  idle_no_count_a: assert property (!s_r.enabled |=> s_r.cnt == HWD_CNT_RESET)
    else $error("Disabled watchdog counter moved.");

  // A key completed in the overflow cycle loses, so that cycle is left out here.
  key_starts_a: assert property (key_done && !pulse && !s_r.ovf && !s_nxt.ovf
    |=> s_r.enabled)
    else $error("Key sequence did not enable the watchdog.");

  key_clears_a: assert property (key_done && !pulse && !s_r.ovf
    |=> s_r.cnt == HWD_CNT_RESET && s_r.pre == HWD_PRE_RESET)
    else $error("Key sequence did not clear the count.");

  armed_on_first_a: assert property (wr_key && sfr_wdata == HWD_KEY_FIRST && !pulse
    && !s_r.ovf && !s_nxt.ovf |=> s_r.armed)
    else $error("First key byte did not arm the sequence.");

  disarm_on_other_a: assert property (sfr_wr
    && !(wr_key && sfr_wdata == HWD_KEY_FIRST) |=> !s_r.armed)
    else $error("Another write left the key sequence armed.");

  // The overflow cycle clears the prescaler instead of stepping it.
  step_on_cycle_a: assert property (run && !key_done && !pulse
    && !s_r.ovf && !s_nxt.ovf |=> s_r.pre == $past(s_r.pre) + 7'h01)
    else $error("Prescaler did not step on a machine cycle.");

  count_step_a: assert property (run && pre_full && !key_done && !pulse
    && !s_r.ovf && !s_nxt.ovf |=> s_r.cnt == $past(s_r.cnt) + 14'h0001)
    else $error("Counter did not step with a full prescaler.");

  count_waits_a: assert property (run && !pre_full && !key_done && !pulse
    && !s_r.ovf |=> $stable(s_r.cnt))
    else $error("Counter stepped before the prescaler was full.");

  stopped_osc_a: assert property (s_r.enabled && !osc_running && !key_done && !pulse
    && !s_r.ovf |=> $stable(s_r.cnt) && $stable(s_r.pre))
    else $error("Counter moved with the oscillator stopped.");

  wake_hold_a: assert property (s_r.hold && !key_done && !pulse && !s_r.ovf
    |=> $stable(s_r.cnt) && $stable(s_r.pre))
    else $error("Counter moved while the wake interrupt was held.");

  hold_on_wake_a: assert property (pd_int_wake |=> s_r.hold)
    else $error("Wake from power-down did not hold the count.");

  hold_ends_a: assert property (!pd_int_wake && ext_int_n |=> !s_r.hold)
    else $error("Count hold outlived the interrupt line.");

  stays_on_a: assert property (s_r.enabled && !s_r.ovf && !pulse && !s_nxt.ovf
    |=> s_r.enabled)
    else $error("Watchdog turned off without a reset.");

  overflow_point_a: assert property (s_r.ovf |-> $past(s_r.cnt) == HWD_CNT_BEFORE_MAX)
    else $error("Overflow at the wrong count.");

  overflow_resets_a: assert property (s_r.ovf |=> !s_r.enabled
    && s_r.sel == HWD_SEL_RESET ##1 rst_pin_o && rst_pin_oe)
    else $error("Overflow did not reset the watchdog and drive the pin.");

  pulse_clears_a: assert property (pulse
    |=> !s_r.enabled && s_r.sel == HWD_SEL_RESET)
    else $error("Watchdog state survived the reset pulse.");

  broken_key_a: assert property (sfr_wr && s_r.armed && !key_done && !s_r.enabled
    |=> !s_r.enabled)
    else $error("Broken key sequence enabled the watchdog.");

  key_reads_zero_a: assert property (sfr_rd && sfr_addr == HWD_ADDR_SERVICE_KEY
    |=> sfr_rdata == HWD_RDATA_RESET)
    else $error("Service key register returned data.");

  sel_write_a: assert property (sfr_wr && sfr_addr == HWD_ADDR_TIMEOUT_SEL && !pulse
    && !s_r.ovf && !s_nxt.ovf |=> {5'h00, s_r.sel} == ($past(sfr_wdata) & 8'h07))
    else $error("Time-out select write was not stored.");

  sel_kept_a: assert property (!(sfr_wr && sfr_addr == HWD_ADDR_TIMEOUT_SEL)
    && !pulse && !s_r.ovf && !s_nxt.ovf |=> $stable(s_r.sel))
    else $error("Time-out select changed without a write.");

  sel_readback_a: assert property (sfr_rd && sfr_addr == HWD_ADDR_TIMEOUT_SEL
    |=> sfr_rdata[7:3] == 5'h00 && sfr_rdata[2:0] == $past(s_r.sel))
    else $error("Time-out select read back wrong.");

endmodule : hwd_watchdog

// ---- tb/hwd_cpu_model.sv ----
// Behavioural CPU that reaches the watchdog through its SFR strobes.
`timescale 1ns/1ps
module hwd_cpu_model
  import hwd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [7:0] sfr_rdata,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic sfr_wr,
  output logic sfr_rd
);
  initial
  begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  end

  // Released lines take the inverse value so that nothing stale can pass for a match.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
    sfr_addr <= ~a;
    sfr_wdata <= ~d;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    sfr_addr <= ~a;
    #1;
    d = sfr_rdata;
  endtask : rd

  task automatic key();
    wr(HWD_ADDR_SERVICE_KEY, HWD_KEY_FIRST);
    wr(HWD_ADDR_SERVICE_KEY, HWD_KEY_SECOND);
  endtask : key
endmodule : hwd_cpu_model

// ---- tb/test_hardware_watchdog_timer.sv ----
// Self-checking bench for the hardware watchdog.
`timescale 1ns/1ps
module test_hardware_watchdog_timer
  import hwd_pkg::*;
;
  logic sys_clk, rst, sfr_wr, sfr_rd, mcycle_tick, osc_running, pd_int_wake, ext_int_n;
  logic periph_tick, rst_pin_o, rst_pin_oe, wdt_enabled;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
  int mismatches = 0;
  int checks = 0;
  int n;
  logic slow_periph;

  hwd_watchdog i_dut (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .mcycle_tick(mcycle_tick), .osc_running(osc_running), .pd_int_wake(pd_int_wake),
    .ext_int_n(ext_int_n), .periph_tick(periph_tick), .rst_pin_o(rst_pin_o),
    .rst_pin_oe(rst_pin_oe), .wdt_enabled(wdt_enabled));
  hwd_cpu_model i_cpu (.sys_clk(sys_clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Peripheral ticks come every cycle, or every other cycle to stretch the reset pulse.
  always @(posedge sys_clk)
  begin
    periph_tick <= slow_periph ? ~periph_tick : 1'b1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  // Counts cycles until the reset pin rises; if it has not risen within hi + 8 cycles the test ends.
  task automatic wait_rise(input int lo, input int hi, input int plen);
    n = 0;
    while (rst_pin_o !== 1'b1 && n < hi + 8)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(16'(n >= lo && n <= hi), 16'h0001);
    if (rst_pin_o !== 1'b1)
      summarize();
    n = 0;
    while (rst_pin_o === 1'b1 && n < 400)
    begin
      check(16'(rst_pin_oe), 16'h0001);
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(16'(n >= plen && n <= plen + 1), 16'h0001);
    check(16'(wdt_enabled), 16'h0000);
    i_cpu.rd(HWD_ADDR_TIMEOUT_SEL, d);
    check(16'(d), 16'h0000);
  endtask : wait_rise

  initial
  begin
    rst = 1'b1;
    mcycle_tick = 1'b0;
    osc_running = 1'b1;
    pd_int_wake = 1'b0;
    ext_int_n = 1'b1;
    slow_periph = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    i_cpu.rd(HWD_ADDR_TIMEOUT_SEL, d);
    check(16'(d), 16'h0000);
    i_cpu.rd(HWD_ADDR_SERVICE_KEY, d);
    check(16'(d), 16'h0000);
    check(16'(wdt_enabled), 16'h0000);
    i_cpu.wr(HWD_ADDR_SERVICE_KEY, HWD_KEY_SECOND);
    i_cpu.wr(HWD_ADDR_SERVICE_KEY, HWD_KEY_FIRST);
    i_cpu.wr(HWD_ADDR_TIMEOUT_SEL, 8'h00);
    i_cpu.wr(HWD_ADDR_SERVICE_KEY, HWD_KEY_SECOND);
    check(16'(wdt_enabled), 16'h0000);
    i_cpu.wr(HWD_ADDR_TIMEOUT_SEL, 8'h07);
    i_cpu.rd(HWD_ADDR_TIMEOUT_SEL, d);
    check(16'(d), 16'h0007);
    i_cpu.wr(HWD_ADDR_TIMEOUT_SEL, 8'h00);
    mcycle_tick <= 1'b1;
    i_cpu.key();
    check(16'(wdt_enabled), 16'h0001);
    i_cpu.wr(HWD_ADDR_SERVICE_KEY, 8'h00);
    i_cpu.wr(HWD_ADDR_TIMEOUT_SEL, 8'h00);
    check(16'(wdt_enabled), 16'h0001);
    repeat (12000) @(posedge sys_clk);
    i_cpu.key();
    repeat (12000) @(posedge sys_clk);
    check(16'(wdt_enabled), 16'h0001);
    check(16'(rst_pin_o), 16'h0000);
    // Counting stops while the oscillator is off and while the wake hold lasts.
    i_cpu.key();
    repeat (6000) @(posedge sys_clk);
    mcycle_tick <= 1'b0;
    repeat (3000) @(posedge sys_clk);
    mcycle_tick <= 1'b1;
    osc_running <= 1'b0;
    repeat (3000) @(posedge sys_clk);
    osc_running <= 1'b1;
    ext_int_n <= 1'b0;
    pd_int_wake <= 1'b1;
    @(posedge sys_clk);
    pd_int_wake <= 1'b0;
    repeat (6000) @(posedge sys_clk);
    ext_int_n <= 1'b1;
    #1;
    check(16'(wdt_enabled), 16'h0001);
    wait_rise(10370, 10395, 96);
    i_cpu.wr(HWD_ADDR_TIMEOUT_SEL, 8'h01);
    slow_periph <= 1'b1;
    i_cpu.key();
    wait_rise(32755, 32775, 191);
    // A hardware reset in mid-run must switch an enabled watchdog off.
    i_cpu.wr(HWD_ADDR_TIMEOUT_SEL, 8'h02);
    i_cpu.key();
    repeat (100) @(posedge sys_clk);
    #1;
    check(16'(wdt_enabled), 16'h0001);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (20) @(posedge sys_clk);
    #1;
    check(16'(wdt_enabled), 16'h0000);
    check(16'(rst_pin_o), 16'h0000);
    i_cpu.rd(HWD_ADDR_TIMEOUT_SEL, d);
    check(16'(d), 16'h0000);
    summarize();
  end
endmodule : test_hardware_watchdog_timer
